//--- logic/alert_gpo_pkg.sv
package alert_gpo_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned CHANNELS = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SRC_SEL_IDX_W = 3;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_UPDATE_EN = 8'hE9;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_ON_ALERT = 8'hEB;
  localparam logic [ADDR_W-1:0] ADDR_PIN_FUNC = 8'hF0;
  localparam logic [ADDR_W-1:0] ADDR_PIN_DIR = 8'hF1;
  localparam logic [ADDR_W-1:0] ADDR_DRIVE = 8'hF2;
  localparam logic [ADDR_W-1:0] ADDR_OUT_VALUE = 8'hF3;
  localparam logic [ADDR_W-1:0] ADDR_IN_LEVEL = 8'hF4;
  // eight consecutive source-select bytes, base aligned to eight
  localparam logic [ADDR_W-1:0] ADDR_SRC_SEL_BASE = 8'hF8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_write_t;

  typedef struct packed {
    logic digital;
    logic output_en;
    logic push_pull;
  } pin_mode_t;

  typedef enum logic [1:0] {
    ROLE_ANALOG,
    ROLE_INPUT,
    ROLE_OPEN_DRAIN,
    ROLE_PUSH_PULL
  } pin_role_t;

endpackage

//--- logic/bit_sync.sv
module bit_sync #(
  parameter int unsigned WIDTH = alert_gpo_pkg::CHANNELS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // two stages; only the second stage is read
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // bit_sync

//--- logic/gpo_channel.sv
module gpo_channel (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // configuration
  input wire alert_gpo_pkg::pin_mode_t i_mode,
  // software write of the level
  input wire logic i_sw_wr,
  input wire logic i_sw_value,
  // alert update
  input wire logic i_trig,
  input wire logic i_trig_level,
  // level and pin
  output logic o_level,
  output logic o_pin_out,
  output logic o_pin_oe
);

  logic level_reg;
  alert_gpo_pkg::pin_role_t role;

  // ----------------------------------------------------------------
  // output level
  // ----------------------------------------------------------------
  // alert update wins over a software write in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      level_reg <= 1'b0;
    end else if (i_trig) begin
      level_reg <= i_trig_level;
    end else if (i_sw_wr) begin
      level_reg <= i_sw_value;
    end
  end

  // ----------------------------------------------------------------
  // pin role and drive
  // ----------------------------------------------------------------
  always_comb begin
    if (!i_mode.digital) begin
      role = alert_gpo_pkg::ROLE_ANALOG;
    end else if (!i_mode.output_en) begin
      role = alert_gpo_pkg::ROLE_INPUT;
    end else if (i_mode.push_pull) begin
      role = alert_gpo_pkg::ROLE_PUSH_PULL;
    end else begin
      role = alert_gpo_pkg::ROLE_OPEN_DRAIN;
    end
  end

  always_comb begin
    o_pin_out = 1'b0;
    o_pin_oe = 1'b0;
    unique case (role)
      alert_gpo_pkg::ROLE_ANALOG, alert_gpo_pkg::ROLE_INPUT: begin
        o_pin_oe = 1'b0;
      end
      alert_gpo_pkg::ROLE_OPEN_DRAIN: begin
        o_pin_out = 1'b0;
        o_pin_oe = !level_reg;
      end
      alert_gpo_pkg::ROLE_PUSH_PULL: begin
        o_pin_out = level_reg;
        o_pin_oe = 1'b1;
      end
    endcase
  end

  assign o_level = level_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_open_drain_drive: assert property (@(posedge i_clk) disable iff (i_srst)
    (role == alert_gpo_pkg::ROLE_OPEN_DRAIN) |-> (o_pin_oe == !o_level) && !o_pin_out)
    else $error("open-drain pin drive wrong");

  chk_push_pull_drive: assert property (@(posedge i_clk) disable iff (i_srst)
    (role == alert_gpo_pkg::ROLE_PUSH_PULL) |-> o_pin_oe && (o_pin_out == o_level))
    else $error("push-pull pin drive wrong");

  chk_input_released: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_mode.digital || !i_mode.output_en |-> !o_pin_oe)
    else $error("input pin is driven");

endmodule // gpo_channel

//--- logic/alert_triggered_output_update.sv
module alert_triggered_output_update (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // register port
  input wire alert_gpo_pkg::reg_write_t i_reg_wr,
  input wire logic [alert_gpo_pkg::ADDR_W-1:0] i_reg_rd_addr,
  output logic [alert_gpo_pkg::DATA_W-1:0] o_reg_rd_data,
  // alert flags from the threshold monitor
  input wire logic [alert_gpo_pkg::CHANNELS-1:0] i_alert_flags,
  // general output pins
  input wire logic [alert_gpo_pkg::CHANNELS-1:0] i_pin_in,
  output logic [alert_gpo_pkg::CHANNELS-1:0] o_pin_out,
  output logic [alert_gpo_pkg::CHANNELS-1:0] o_pin_oe
);

  localparam int unsigned N = alert_gpo_pkg::CHANNELS;
  localparam int unsigned AW = alert_gpo_pkg::ADDR_W;
  localparam int unsigned DW = alert_gpo_pkg::DATA_W;
  localparam int unsigned SW = alert_gpo_pkg::SRC_SEL_IDX_W;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [N-1:0] alert_update_enable_bits_reg;
  logic [N-1:0] alert_level_bits_reg;
  logic [N-1:0] pin_func_reg;
  logic [N-1:0] pin_dir_reg;
  logic [N-1:0] drive_reg;
  logic [DW-1:0] alert_source_select_reg [N];
  logic [N-1:0] alert_prev_reg;
  logic [DW-1:0] rd_data_reg;

  logic [N-1:0] pin_sync;
  logic [N-1:0] input_pin_level;
  logic [N-1:0] input_mask;
  logic [N-1:0] alert_rise;
  logic [N-1:0] sel_hit;
  logic [N-1:0] trig;
  logic [N-1:0] out_level;
  logic out_wr;
  logic [DW-1:0] rd_data_next;

  function automatic logic wr_hit(input logic [AW-1:0] addr);
    wr_hit = i_reg_wr.wr && (i_reg_wr.addr == addr);
  endfunction

  assign out_wr = wr_hit(alert_gpo_pkg::ADDR_OUT_VALUE);

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      alert_update_enable_bits_reg <= alert_gpo_pkg::RST_BYTE;
    end else if (wr_hit(alert_gpo_pkg::ADDR_UPDATE_EN)) begin
      alert_update_enable_bits_reg <= i_reg_wr.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      alert_level_bits_reg <= alert_gpo_pkg::RST_BYTE;
    end else if (wr_hit(alert_gpo_pkg::ADDR_LEVEL_ON_ALERT)) begin
      alert_level_bits_reg <= i_reg_wr.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_func_reg <= alert_gpo_pkg::RST_BYTE;
      pin_dir_reg <= alert_gpo_pkg::RST_BYTE;
      drive_reg <= alert_gpo_pkg::RST_BYTE;
    end else begin
      if (wr_hit(alert_gpo_pkg::ADDR_PIN_FUNC)) begin
        pin_func_reg <= i_reg_wr.data;
      end
      if (wr_hit(alert_gpo_pkg::ADDR_PIN_DIR)) begin
        pin_dir_reg <= i_reg_wr.data;
      end
      if (wr_hit(alert_gpo_pkg::ADDR_DRIVE)) begin
        drive_reg <= i_reg_wr.data;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int i = 0; i < N; i++) begin
        alert_source_select_reg[i] <= alert_gpo_pkg::RST_BYTE;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_hit(AW'(alert_gpo_pkg::ADDR_SRC_SEL_BASE + AW'(i)))) begin
          alert_source_select_reg[i] <= i_reg_wr.data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // alert edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      alert_prev_reg <= alert_gpo_pkg::RST_BYTE;
    end else begin
      alert_prev_reg <= i_alert_flags;
    end
  end

  // a flag held high produces one rise only
  assign alert_rise = i_alert_flags & ~alert_prev_reg;

  // ----------------------------------------------------------------
  // output channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_ch
    alert_gpo_pkg::pin_mode_t mode;
    assign mode = '{digital: pin_func_reg[g], output_en: pin_dir_reg[g],
                    push_pull: drive_reg[g]};
    assign sel_hit[g] = |(alert_source_select_reg[g] & alert_rise);
    assign trig[g] = alert_update_enable_bits_reg[g] && sel_hit[g];

    gpo_channel u_channel (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_mode(mode),
      .i_sw_wr(out_wr),
      .i_sw_value(i_reg_wr.data[g]),
      .i_trig(trig[g]),
      .i_trig_level(alert_level_bits_reg[g]),
      .o_level(out_level[g]),
      .o_pin_out(o_pin_out[g]),
      .o_pin_oe(o_pin_oe[g])
    );
  end

  // ----------------------------------------------------------------
  // pin input path
  // ----------------------------------------------------------------
  bit_sync #(
    .WIDTH(N)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async(i_pin_in),
    .o_sync(pin_sync)
  );

  assign input_mask = pin_func_reg & ~pin_dir_reg;
  assign input_pin_level = pin_sync & input_mask;

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_next = alert_gpo_pkg::UNMAPPED_READ;
    if (i_reg_rd_addr[AW-1:SW] == alert_gpo_pkg::ADDR_SRC_SEL_BASE[AW-1:SW]) begin
      rd_data_next = alert_source_select_reg[i_reg_rd_addr[SW-1:0]];
    end else begin
      unique case (i_reg_rd_addr)
        alert_gpo_pkg::ADDR_UPDATE_EN: rd_data_next = alert_update_enable_bits_reg;
        alert_gpo_pkg::ADDR_LEVEL_ON_ALERT: rd_data_next = alert_level_bits_reg;
        alert_gpo_pkg::ADDR_PIN_FUNC: rd_data_next = pin_func_reg;
        alert_gpo_pkg::ADDR_PIN_DIR: rd_data_next = pin_dir_reg;
        alert_gpo_pkg::ADDR_DRIVE: rd_data_next = drive_reg;
        alert_gpo_pkg::ADDR_OUT_VALUE: rd_data_next = out_level;
        alert_gpo_pkg::ADDR_IN_LEVEL: rd_data_next = input_pin_level;
        default: rd_data_next = alert_gpo_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_data_reg <= alert_gpo_pkg::RST_BYTE;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign o_reg_rd_data = rd_data_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (i_srst);

  sequence s_level_write;
    wr_hit(alert_gpo_pkg::ADDR_LEVEL_ON_ALERT);
  endsequence

  sequence s_level_read;
    i_reg_rd_addr == alert_gpo_pkg::ADDR_LEVEL_ON_ALERT;
  endsequence

  sequence s_pins_settled;
    $stable(i_pin_in) [*3];
  endsequence

  chk_trigger_applies_level: assert property (
    (|trig) |=> ((out_level & $past(trig)) == ($past(alert_level_bits_reg) & $past(trig))))
    else $error("alert update did not apply the level");

  chk_disabled_holds_output: assert property (
    !out_wr |=> ((out_level ^ $past(out_level)) & ~$past(alert_update_enable_bits_reg)) == '0)
    else $error("disabled output changed on alert");

  chk_source_limits_update: assert property (
    !out_wr |=> ((out_level ^ $past(out_level)) & ~$past(sel_hit)) == '0)
    else $error("unselected flag changed an output");

  chk_level_needs_enable: assert property (
    s_level_write ##0 (trig == '0) ##0 !out_wr |=> $stable(out_level))
    else $error("level write moved an output");

  chk_level_readback: assert property (
    s_level_write ##1 s_level_read |=> o_reg_rd_data == $past(i_reg_wr.data, 2))
    else $error("alert level register readback wrong");

  chk_level_reset_zero: assert property (disable iff (1'b0)
    i_srst |=> alert_level_bits_reg == alert_gpo_pkg::RST_BYTE)
    else $error("alert level register not cleared by reset");

  chk_input_readback: assert property (
    s_pins_settled ##0 (i_reg_rd_addr == alert_gpo_pkg::ADDR_IN_LEVEL)
      |=> o_reg_rd_data == ($past(i_pin_in) & $past(input_mask)))
    else $error("input level readback wrong");

  chk_no_retrigger: assert property (
    (alert_rise == '0) && !out_wr |=> $stable(out_level))
    else $error("output changed without a rising alert");

  sequence s_out_write;
    wr_hit(alert_gpo_pkg::ADDR_OUT_VALUE);
  endsequence

  chk_sw_write_lands: assert property (
    s_out_write ##0 (trig == '0) |=> out_level == $past(i_reg_wr.data))
    else $error("software output write lost");

  chk_level_only_by_write: assert property (
    !wr_hit(alert_gpo_pkg::ADDR_LEVEL_ON_ALERT) |=> $stable(alert_level_bits_reg))
    else $error("alert level register changed without a write");

  chk_enable_only_by_write: assert property (
    !wr_hit(alert_gpo_pkg::ADDR_UPDATE_EN) |=> $stable(alert_update_enable_bits_reg))
    else $error("update enable register changed without a write");

  chk_enable_reset_zero: assert property (disable iff (1'b0)
    i_srst |=> alert_update_enable_bits_reg == alert_gpo_pkg::RST_BYTE)
    else $error("update enable register not cleared by reset");

  chk_reset_releases_pins: assert property (disable iff (1'b0)
    i_srst |=> (o_pin_oe == '0) && (o_pin_out == '0))
    else $error("pins driven after reset");

  chk_open_drain_no_high: assert property (
    (o_pin_oe & o_pin_out & pin_func_reg & pin_dir_reg & ~drive_reg) == '0)
    else $error("open-drain pin driven high");

  chk_od_releases_high: assert property (
    (pin_func_reg & pin_dir_reg & ~drive_reg & out_level & o_pin_oe) == '0)
    else $error("open-drain pin not released for a high level");

  chk_push_pull_driven: assert property (
    (pin_func_reg & pin_dir_reg & drive_reg & ~o_pin_oe) == '0)
    else $error("push-pull pin left undriven");

  chk_input_undriven: assert property (
    (~(pin_func_reg & pin_dir_reg) & o_pin_oe) == '0)
    else $error("input or analog pin driven");

  chk_in_level_masked: assert property (
    (i_reg_rd_addr == alert_gpo_pkg::ADDR_IN_LEVEL)
      |=> (o_reg_rd_data & ~$past(input_mask)) == '0)
    else $error("non-input pin shown in input level");

  chk_unmapped_reads_zero: assert property (
    (i_reg_rd_addr < alert_gpo_pkg::ADDR_UPDATE_EN)
      |=> o_reg_rd_data == alert_gpo_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");

  // per output: selected rising flag on an enabled output loads its level
  for (genvar c = 0; c < N; c++) begin : g_chk_update
    chk_rise_updates_output: assert property (@(posedge i_clk) disable iff (i_srst)
      alert_update_enable_bits_reg[c]
        && |(alert_source_select_reg[c] & i_alert_flags & ~$past(i_alert_flags))
        |=> out_level[c] == $past(alert_level_bits_reg[c]))
      else $error("selected rising alert did not update its output");
  end

endmodule // alert_triggered_output_update

//--- testbench/pin_receiver.sv
module pin_receiver (
  // pins from the device
  input wire logic [alert_gpo_pkg::CHANNELS-1:0] i_pin_out,
  input wire logic [alert_gpo_pkg::CHANNELS-1:0] i_pin_oe,
  // board side: pull-ups and outside drivers of undriven pins
  input wire logic [alert_gpo_pkg::CHANNELS-1:0] i_pull_up,
  input wire logic [alert_gpo_pkg::CHANNELS-1:0] i_ext_level,
  output logic [alert_gpo_pkg::CHANNELS-1:0] o_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // resolved wire level
  // ----------------------------------------------------------------
  // released pin shows the pull-up, else the outside driver
  always_comb begin
    for (int k = 0; k < alert_gpo_pkg::CHANNELS; k++) begin
      o_wire[k] = i_pin_oe[k] ? i_pin_out[k] : (i_pull_up[k] ? 1'b1 : i_ext_level[k]);
    end
  end
endmodule // pin_receiver

//--- testbench/alert_triggered_output_update_tb_top.sv
module alert_triggered_output_update_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  alert_gpo_pkg::reg_write_t reg_wr = '0;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] rd_data;
  logic [7:0] flags = 8'h00;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] pull_up = 8'hFF;
  logic [7:0] ext_level = 8'h00;
  int mismatches = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  alert_triggered_output_update dut (
    .i_clk(clk),
    .i_srst(srst),
    .i_reg_wr(reg_wr),
    .i_reg_rd_addr(rd_addr),
    .o_reg_rd_data(rd_data),
    .i_alert_flags(flags),
    .i_pin_in(pin_in),
    .o_pin_out(pin_out),
    .o_pin_oe(pin_oe)
  );

  pin_receiver board (
    .i_pin_out(pin_out),
    .i_pin_oe(pin_oe),
    .i_pull_up(pull_up),
    .i_ext_level(ext_level),
    .o_wire(pin_in)
  );

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_wr <= '{wr: 1'b1, addr: addr, data: data};
    @(posedge clk);
    reg_wr <= '0;
  endtask

  // read data lags the address by one cycle
  task automatic rd(input string name, input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    rd_addr <= addr;
    @(posedge clk);
    #1;
    chk(name, exp, rd_data);
  endtask

  task automatic set_flags(input logic [7:0] v);
    @(posedge clk);
    flags <= v;
  endtask

  task automatic chk_pins(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] w);
    chk("pin_oe", oe, pin_oe);
    chk("pin_out", out, pin_out);
    chk("wire", w, pin_in);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // reset values of every mapped byte except the input level, and an unmapped one
    rd("update_en", alert_gpo_pkg::ADDR_UPDATE_EN, 8'h00);
    rd("level_on_alert", alert_gpo_pkg::ADDR_LEVEL_ON_ALERT, 8'h00);
    for (int a = 8'hF0; a <= 8'hF3; a++) begin
      rd("cfg_reset", 8'(a), 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      rd("src_reset", alert_gpo_pkg::ADDR_SRC_SEL_BASE + 8'(i), 8'h00);
    end
    rd("unmapped", 8'h10, alert_gpo_pkg::UNMAPPED_READ);
    chk_pins(8'h00, 8'h00, 8'hFF);
    wr(alert_gpo_pkg::ADDR_LEVEL_ON_ALERT, 8'hA5);
    rd("level_rw", alert_gpo_pkg::ADDR_LEVEL_ON_ALERT, 8'hA5);
    // pins 0-3 push-pull, 4-7 open-drain, output i listens to flag i+1, output 7 to flag 0
    wr(alert_gpo_pkg::ADDR_PIN_FUNC, 8'hFF);
    wr(alert_gpo_pkg::ADDR_PIN_DIR, 8'hFF);
    wr(alert_gpo_pkg::ADDR_DRIVE, 8'h0F);
    wr(alert_gpo_pkg::ADDR_LEVEL_ON_ALERT, 8'h0F);
    wr(alert_gpo_pkg::ADDR_UPDATE_EN, 8'h55);
    for (int i = 0; i < 8; i++) begin
      wr(alert_gpo_pkg::ADDR_SRC_SEL_BASE + 8'(i), 8'h01 << ((i + 1) % 8));
    end
    chk_pins(8'hFF, 8'h00, 8'h00);
    // flag 0 feeds only output 7, which is not enabled
    set_flags(8'h01);
    rd("flag0", alert_gpo_pkg::ADDR_OUT_VALUE, 8'h00);
    set_flags(8'h03);
    rd("flag1", alert_gpo_pkg::ADDR_OUT_VALUE, 8'h01);
    // flags held high must not reapply after software clears
    wr(alert_gpo_pkg::ADDR_OUT_VALUE, 8'h00);
    rd("held", alert_gpo_pkg::ADDR_OUT_VALUE, 8'h00);
    wr(alert_gpo_pkg::ADDR_OUT_VALUE, 8'hFF);
    set_flags(8'h00);
    set_flags(8'hFF);
    rd("all_rise", alert_gpo_pkg::ADDR_OUT_VALUE, 8'hAF);
    chk_pins(8'h5F, 8'h0F, 8'hAF);
    // inputs: only digital pins show their level
    @(posedge clk);
    pull_up <= 8'h00;
    ext_level <= 8'h3C;
    wr(alert_gpo_pkg::ADDR_PIN_DIR, 8'h00);
    wr(alert_gpo_pkg::ADDR_PIN_FUNC, 8'h0F);
    repeat (4) @(posedge clk);
    rd("in_level", alert_gpo_pkg::ADDR_IN_LEVEL, 8'h0C);
    wr(alert_gpo_pkg::ADDR_IN_LEVEL, 8'hFF);
    rd("in_level_ro", alert_gpo_pkg::ADDR_IN_LEVEL, 8'h0C);
    chk_pins(8'h00, 8'h00, 8'h3C);
    // second reset in mid-run clears the level register
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd("level_rst", alert_gpo_pkg::ADDR_LEVEL_ON_ALERT, 8'h00);
    give_verdict();
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    #20000;
    mismatches++;
    give_verdict();
  end
endmodule // alert_triggered_output_update_tb_top
